// ### afc_ctrl.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
`default_nettype none
module afc_ctrl
   import afc_pkg::*;
(
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Buffer device pins
   output logic                   put_strobe_n,
   output logic                   get_pulse_n,
   output logic                   clear_all_n,
   output logic                   replay_n,
   output logic [DATA_W-1:0]      push_word,
   input  wire logic [DATA_W-1:0] pop_word,
   input  wire logic              no_data_flag,
   input  wire logic              no_room_flag,
   input  wire logic              half_level_flag
);
   afc_regs_t r_q;
   afc_regs_t r_d;

   function automatic logic [31:0] status_word(afc_regs_t r);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[ST_BUSY]    = (r.st != S_IDLE);
      w[ST_EMPTY_N] = r.flag_s2[0];
      w[ST_FULL_N]  = r.flag_s2[1];
      w[ST_HALF_N]  = r.flag_s2[2];
      w[ST_RVALID]  = r.rvalid;
      w[ST_DROPPED] = r.dropped;
      return w;
   endfunction : status_word

   logic acc;
   assign acc = psel & penable & ~r_q.pready;

   // Writes and read side effects land only on the completing edge
   logic done;
   assign done = psel & penable & r_q.pready;

   always_comb
   begin
      r_d = r_q;
      r_d.pready  = acc;
      r_d.flag_s1 = {half_level_flag, no_room_flag, no_data_flag};
      r_d.flag_s2 = r_q.flag_s1;
      r_d.pop_s1  = pop_word;
      r_d.pop_s2  = r_q.pop_s1;
      if (acc && !pwrite)
      begin
         unique case (paddr)
            OFF_CTRL:   r_d.prdata = {28'h000_0000, r_q.cmd};
            OFF_WDATA:  r_d.prdata = {23'h00_0000, r_q.wdata};
            OFF_RDATA:  r_d.prdata = {23'h00_0000, r_q.rdata};
            OFF_STATUS: r_d.prdata = status_word(r_q);
            default:    r_d.prdata = 32'h0000_0000;
         endcase
      end
      if (done && !pwrite && paddr == OFF_RDATA)
         r_d.rvalid = 1'b0;
      if (done && pwrite && paddr == OFF_WDATA)
         r_d.wdata = pwdata[DATA_W-1:0];
      if (done && pwrite && paddr == OFF_STATUS && pwdata[ST_DROPPED])
         r_d.dropped = 1'b0;
      unique case (r_q.st)
         S_IDLE:
         begin
            if (done && pwrite && paddr == OFF_CTRL && pwdata[3:0] != 4'h0)
            begin
               r_d.cmd  = pwdata[3:0];
               r_d.st   = S_SETUP;
               r_d.cnt  = N_SETUP;
               // Strobes already high from idle
               r_d.pins.push_word = r_q.wdata;
            end
         end
         S_SETUP:
         begin
            if (r_q.cnt > 4'h1)
               r_d.cnt = r_q.cnt - 4'h1;
            else
            begin
               r_d.st  = S_PULSE;
               r_d.cnt = N_PULSE;
               if (r_q.cmd[CMD_RESET])
                  r_d.pins.clear_all_n = 1'b0;
               else if (r_q.cmd[CMD_REPLAY])
                  r_d.pins.replay_n = 1'b0;
               else if (r_q.cmd[CMD_WRITE])
               begin
                  // Guard overflow from host side too
                  if (r_q.flag_s2[1])
                     r_d.pins.put_strobe_n = 1'b0;
                  else
                     r_d.dropped = 1'b1;
               end
               else
               begin
                  if (r_q.flag_s2[0])
                  begin
                     r_d.pins.get_pulse_n = 1'b0;
                     r_d.cnt = (N_ACCESS > N_PULSE) ? N_ACCESS : N_PULSE;
                  end
                  else
                     r_d.dropped = 1'b1;
               end
            end
         end
         S_PULSE:
         begin
            if (r_q.cnt > 4'h1)
               r_d.cnt = r_q.cnt - 4'h1;
            else
            begin
               // Sample before release; outputs float after
               if (!r_q.pins.get_pulse_n)
               begin
                  r_d.rdata  = r_q.pop_s2;
                  r_d.rvalid = 1'b1;
               end
               r_d.pins.put_strobe_n = 1'b1;
               r_d.pins.get_pulse_n  = 1'b1;
               r_d.pins.clear_all_n  = 1'b1;
               r_d.pins.replay_n     = 1'b1;
               r_d.st  = S_RECOV;
               // Flags need time to settle through sync
               r_d.cnt = N_RECOV + N_FLAG + 4'h2;
            end
         end
         S_RECOV:
         begin
            if (r_q.cnt > 4'h1)
               r_d.cnt = r_q.cnt - 4'h1;
            else
            begin
               r_d.st  = S_IDLE;
               r_d.cmd = 4'h0;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_q <= '{st: S_IDLE, cmd: 4'h0, cnt: 4'h0,
                  pins: '{put_strobe_n: 1'b1, get_pulse_n: 1'b1,
                          clear_all_n: 1'b1, replay_n: 1'b1,
                          push_word: 9'h000},
                  wdata: 9'h000, rdata: 9'h000, rvalid: 1'b0,
                  dropped: 1'b0, flag_s1: 3'h0, flag_s2: 3'h0,
                  pop_s1: 9'h000, pop_s2: 9'h000, pready: 1'b0,
                  prdata: 32'h0000_0000};
      end
      else
         r_q <= r_d;
   end

   assign pready       = r_q.pready;
   assign prdata       = r_q.prdata;
   assign pslverr      = 1'b0;
   assign put_strobe_n = r_q.pins.put_strobe_n;
   assign get_pulse_n  = r_q.pins.get_pulse_n;
   assign clear_all_n  = r_q.pins.clear_all_n;
   assign replay_n     = r_q.pins.replay_n;
   assign push_word    = r_q.pins.push_word;
endmodule : afc_ctrl
`default_nettype wire

// ### afc_pkg.sv
`default_nettype none
package afc_pkg;
   localparam int unsigned DATA_W      = 9;
   localparam int unsigned ADDR_W      = 12;
   // APB register byte offsets
   localparam logic [11:0] OFF_CTRL    = 12'h000;
   localparam logic [11:0] OFF_WDATA   = 12'h004;
   localparam logic [11:0] OFF_RDATA   = 12'h008;
   localparam logic [11:0] OFF_STATUS  = 12'h00C;
   // CTRL command bits (write one to start)
   localparam int unsigned CMD_WRITE   = 0;
   localparam int unsigned CMD_READ    = 1;
   localparam int unsigned CMD_REPLAY  = 2;
   localparam int unsigned CMD_RESET   = 3;
   // STATUS bit positions
   localparam int unsigned ST_BUSY     = 0;
   localparam int unsigned ST_EMPTY_N  = 1;
   localparam int unsigned ST_FULL_N   = 2;
   localparam int unsigned ST_HALF_N   = 3;
   localparam int unsigned ST_RVALID   = 4;
   localparam int unsigned ST_DROPPED  = 5;
   // Pin timing, ns, slowest speed grade
   localparam int unsigned CLK_NS      = 8;
   localparam int unsigned T_PULSE_NS  = 20;
   localparam int unsigned T_RECOV_NS  = 10;
   localparam int unsigned T_ACCESS_NS = 20;
   localparam int unsigned T_FLAG_NS   = 20;
   localparam int unsigned T_SETUP_NS  = 12;
   // Least times round up
   localparam logic [3:0] N_PULSE  =
      4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] N_RECOV  =
      4'((T_RECOV_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] N_ACCESS =
      4'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] N_FLAG   =
      4'((T_FLAG_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] N_SETUP  =
      4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);

   typedef enum {
      S_IDLE,
      S_SETUP,
      S_PULSE,
      S_RECOV
   } afc_state_t;

   typedef struct packed {
      logic              put_strobe_n;
      logic              get_pulse_n;
      logic              clear_all_n;
      logic              replay_n;
      logic [DATA_W-1:0] push_word;
   } afc_pins_t;

   typedef struct packed {
      afc_state_t        st;
      logic [3:0]        cmd;
      logic [3:0]        cnt;
      afc_pins_t         pins;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic              rvalid;
      logic              dropped;
      logic [2:0]        flag_s1;
      logic [2:0]        flag_s2;
      logic [DATA_W-1:0] pop_s1;
      logic [DATA_W-1:0] pop_s2;
      logic              pready;
      logic [31:0]       prdata;
   } afc_regs_t;
endpackage : afc_pkg
`default_nettype wire

// ### afc_ctrl_asserts.sv
`default_nettype none
module afc_ctrl_asserts
   import afc_pkg::*;
(
   // Bus side
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pready,
   // Device pins
   input wire logic              put_strobe_n,
   input wire logic              get_pulse_n,
   input wire logic              clear_all_n,
   input wire logic              replay_n,
   input wire logic [DATA_W-1:0] push_word
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_low3(s);
      (!s)[*3] ##1 s;
   endsequence
   a_pready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_pready_once: assert property (pready |=> !pready)
      else $error("pready held");
   a_put_width: assert property (
      $fell(put_strobe_n) |-> s_low3(put_strobe_n)) else $error("put width");
   a_get_width: assert property (
      $fell(get_pulse_n) |-> s_low3(get_pulse_n)) else $error("get width");
   a_word_hold: assert property (
      !put_strobe_n |-> $stable(push_word)) else $error("word moved");
   a_put_recov: assert property (
      $rose(put_strobe_n) |-> put_strobe_n[*3]) else $error("put recovery");
   a_replay_quiet: assert property (
      !replay_n |-> put_strobe_n && get_pulse_n) else $error("replay strobe");
   a_clear_quiet: assert property (
      !clear_all_n |-> put_strobe_n && get_pulse_n) else $error("clear strobe");
endmodule : afc_ctrl_asserts
bind afc_ctrl afc_ctrl_asserts u_chk (.pclk, .presetn, .psel, .penable,
   .pready, .put_strobe_n, .get_pulse_n, .clear_all_n, .replay_n, .push_word);
`default_nettype wire

// ### afc_dev_model.sv
`default_nettype none
module afc_dev_model
   import afc_pkg::*;
(
   // Strobes and data in
   input wire logic              put_strobe_n,
   input wire logic              get_pulse_n,
   input wire logic              clear_all_n,
   input wire logic              replay_n,
   input wire logic [DATA_W-1:0] push_word,
   // Data and flags out
   output logic [DATA_W-1:0]     pop_word,
   output logic                  no_data_flag,
   output logic                  no_room_flag,
   output logic                  half_level_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [512];
   logic [DATA_W-1:0] q = '0;
   logic [9:0]        wp = '0, rp = '0, cnt;
   logic              rd = 0;
   assign cnt = wp - rp;
   assign no_data_flag = cnt != 0;
   assign no_room_flag = cnt != 10'd512;
   // Standalone only: pin is the half flag, no chain token
   assign half_level_flag = !(cnt > 10'd256);
   // Floating bus shows the inverse so a stale value cannot pass
   assign pop_word = (!get_pulse_n && rd) ? q : ~q;
   always @(negedge clear_all_n)
   begin
      wp = '0;
      rp = '0;
   end
   always @(negedge replay_n)
      rp = '0;
   always @(posedge put_strobe_n)
      if (cnt != 10'd512)
      begin
         mem[wp[8:0]] = push_word;
         wp = wp + 10'd1;
      end
   always @(negedge get_pulse_n)
   begin
      rd = cnt != 0;
      q = mem[rp[8:0]];
   end
   always @(posedge get_pulse_n)
      if (rd)
         rp = rp + 10'd1;
endmodule : afc_dev_model
`default_nettype wire

// ### async_fifo_512x9_bench.sv
`default_nettype none
module async_fifo_512x9_bench
   import afc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, put_strobe_n, get_pulse_n, clear_all_n, replay_n;
   logic no_data_flag, no_room_flag, half_level_flag;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd;
   logic [DATA_W-1:0] push_word, pop_word, exp_q[$];
   int n_errors = 0, checked = 0, seed = 19245, n = 0, i;
   always #4 pclk = ~pclk;
   afc_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .prdata, .pslverr, .put_strobe_n, .get_pulse_n,
      .clear_all_n, .replay_n, .push_word, .pop_word, .no_data_flag,
      .no_room_flag, .half_level_flag);
   afc_dev_model dev_u (.put_strobe_n, .get_pulse_n, .clear_all_n,
      .replay_n, .push_word, .pop_word, .no_data_flag, .no_room_flag,
      .half_level_flag);
   function automatic logic [2:0] fl(input int c);
      return {c <= 256, c != 512, c != 0};
   endfunction : fl
   task automatic tally_and_finish(input bit hung);
      n_errors += hung;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic check(input string w, input logic [31:0] s, e);
      checked++;
      if (s !== e)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", w, e, s);
      end
   endtask : check
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
      input logic [31:0] v);
      int k;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
      if (k == 20)
         tally_and_finish(1);
      rd = prdata;
      psel <= 0;
      penable <= 0;
      // Idle cycle keeps each strobe to one assignment per step
      @(posedge pclk);
   endtask : apb
   task automatic cmd(input int b);
      int k;
      apb(1, OFF_CTRL, 32'h1 << b);
      for (k = 0; k < 40; k++)
      begin
         apb(0, OFF_STATUS, 0);
         if (rd[ST_BUSY] === 1'b0)
            break;
      end
      if (k == 40)
         tally_and_finish(1);
   endtask : cmd
   task automatic push(input logic [DATA_W-1:0] v);
      apb(1, OFF_WDATA, {23'h0, v});
      cmd(CMD_WRITE);
      check("drop", rd[ST_DROPPED], n == 512);
      if (n < 512)
         exp_q.push_back(v);
      n += n < 512;
      check("flags", rd[3:1], fl(n));
   endtask : push
   task automatic pop(input int j);
      cmd(CMD_READ);
      n--;
      check("flags", rd[3:1], fl(n));
      check("rvalid", rd[ST_RVALID], 1);
      apb(0, OFF_RDATA, 0);
      check("word", rd, {23'h0, exp_q[j]});
   endtask : pop
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      cmd(CMD_RESET);
      check("flags", rd[3:1], fl(0));
      cmd(CMD_READ);
      check("drop", rd[ST_DROPPED], 1);
      apb(0, 12'h010, 0);
      check("unmapped", rd, 0);
      apb(1, OFF_STATUS, 32'h20);
      for (i = 0; i < 513; i++)
         push(i == 1 ? 9'h1FF : 9'($random(seed)));
      apb(1, OFF_STATUS, 32'h20);
      for (i = 0; i < 512; i++)
         pop(i);
      cmd(CMD_READ);
      check("drop", rd[ST_DROPPED], 1);
      cmd(CMD_REPLAY);
      n = 512;
      check("flags", rd[3:1], fl(n));
      for (i = 0; i < 3; i++)
         pop(i);
      cmd(CMD_RESET);
      check("flags", rd[3:1], fl(0));
      tally_and_finish(0);
   end
endmodule : async_fifo_512x9_bench
`default_nettype wire
